// file: tpr_recal_ctrl.sv
// baseline recalibration averaging, update period and negative run counting
`timescale 1ns/100ps
`default_nettype none
module tpr_recal_ctrl (
  // clock and reset
  input  wire logic                                       mclk_i,
  input  wire logic                                       reset_n_i,
  // measurement stream
  input  wire logic                                       cycle_done_i,
  input  wire logic [tpr_pkg::NUM_IN-1:0]                 sample_valid_i,
  input  wire logic [tpr_pkg::NUM_IN-1:0][tpr_pkg::SAMPLE_W-1:0] sample_i,
  input  wire logic [tpr_pkg::NUM_IN-1:0]                 neg_delta_i,
  input  wire logic [tpr_pkg::NUM_IN-1:0]                 noise_i,
  // configuration
  input  var  tpr_pkg::tpr_recal_t                        cfg_i,
  // results
  output logic [tpr_pkg::NUM_IN-1:0]                      base_update_o,
  output logic [tpr_pkg::NUM_IN-1:0][tpr_pkg::SAMPLE_W-1:0] base_o,
  output logic [tpr_pkg::NUM_IN-1:0]                      recal_req_o
);
  // ==========================================================
  // decode, shared by all inputs
  logic [3:0]                  avg_sh;
  logic [3:0]                  per_sh;
  logic [tpr_pkg::SCNT_W-1:0]  nsamp;
  logic [tpr_pkg::PCNT_W-1:0]  period;
  logic [tpr_pkg::NCNT_W-1:0]  neg_lim;
  logic                        neg_off;
  always_comb
  begin
    if (cfg_i.cal_cfg > tpr_pkg::CAL_MAX_AVG) // (R12)
      avg_sh = tpr_pkg::AVG_SH_MAX;
    else
      avg_sh = tpr_pkg::AVG_SH_BASE + {1'b0, cfg_i.cal_cfg};
    case (cfg_i.cal_cfg) // (R13)
      3'h5:    per_sh = tpr_pkg::PER_SH_5;
      3'h6:    per_sh = tpr_pkg::PER_SH_6;
      3'h7:    per_sh = tpr_pkg::PER_SH_7;
      default: per_sh = tpr_pkg::AVG_SH_BASE + {1'b0, cfg_i.cal_cfg};
    endcase
    nsamp   = tpr_pkg::SCNT_W'(1) << avg_sh;
    period  = tpr_pkg::PCNT_W'(1) << per_sh;
    neg_off = 1'b0;
    case (cfg_i.negative_run_limit) // (R11)
      tpr_pkg::NEG_LIM_8:  neg_lim = tpr_pkg::NEG_CNT_8;
      tpr_pkg::NEG_LIM_16: neg_lim = tpr_pkg::NEG_CNT_16;
      tpr_pkg::NEG_LIM_32: neg_lim = tpr_pkg::NEG_CNT_32;
      default:
      begin
        neg_lim = tpr_pkg::NEG_CNT_32;
        neg_off = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // update period in sensing cycles
  logic [tpr_pkg::PCNT_W-1:0] pcnt_r;
  logic [tpr_pkg::PCNT_W-1:0] pcnt_nxt;
  logic                       per_end;
  always_comb
  begin
    pcnt_nxt = pcnt_r;
    per_end  = 1'b0;
    if (cycle_done_i)
    begin
      if (pcnt_r + tpr_pkg::PCNT_W'(1) >= period) // (R13) (R14)
      begin
        pcnt_nxt = '0;
        per_end  = 1'b1;
      end
      else
        pcnt_nxt = pcnt_r + tpr_pkg::PCNT_W'(1);
    end
  end
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pcnt_r <= '0;
    else
      pcnt_r <= pcnt_nxt;
  end

  // ==========================================================
  // per input averaging and negative run counter
  genvar gi;
  generate
    for (gi = 0; gi < tpr_pkg::NUM_IN; gi++)
    begin : g_in
      logic [tpr_pkg::ACC_W-1:0]    acc_r, acc_nxt, sum;
      logic [tpr_pkg::SCNT_W-1:0]   scnt_r, scnt_nxt;
      logic [tpr_pkg::SAMPLE_W-1:0] avg_r, avg_nxt;
      logic                         have_r, have_nxt;
      logic [tpr_pkg::NCNT_W-1:0]   ncnt_r, ncnt_nxt;
      logic                         req_nxt, upd_nxt;
      logic [tpr_pkg::SAMPLE_W-1:0] base_nxt;
      always_comb
      begin
        sum      = acc_r + {{(tpr_pkg::ACC_W-tpr_pkg::SAMPLE_W){1'b0}}, sample_i[gi]};
        acc_nxt  = acc_r;
        scnt_nxt = scnt_r;
        avg_nxt  = avg_r;
        have_nxt = have_r;
        if (noise_i[gi] && !cfg_i.keep_intermediate_on_noise) // (R8)
        begin
          acc_nxt  = '0;
          scnt_nxt = '0;
        end
        else if (sample_valid_i[gi])
        begin
          if (scnt_r + tpr_pkg::SCNT_W'(1) >= nsamp) // (R12) (R14)
          begin
            avg_nxt  = tpr_pkg::SAMPLE_W'(sum >> avg_sh);
            have_nxt = 1'b1;
            acc_nxt  = '0;
            scnt_nxt = '0;
          end
          else
          begin
            acc_nxt  = sum;
            scnt_nxt = scnt_r + tpr_pkg::SCNT_W'(1);
          end
        end
        upd_nxt  = per_end & have_r; // (R14) (R15)
        base_nxt = upd_nxt ? avg_r : base_o[gi];
        ncnt_nxt = ncnt_r;
        req_nxt  = 1'b0;
        if (noise_i[gi] && !cfg_i.keep_negative_count_on_noise) // (R9)
          ncnt_nxt = '0;
        else if (sample_valid_i[gi])
        begin
          if (!neg_delta_i[gi])
            ncnt_nxt = '0;
          else if (!neg_off && ncnt_r + tpr_pkg::NCNT_W'(1) >= neg_lim) // (R11)
          begin
            ncnt_nxt = '0;
            req_nxt  = 1'b1;
          end
          else if (ncnt_r != {tpr_pkg::NCNT_W{1'b1}})
            ncnt_nxt = ncnt_r + tpr_pkg::NCNT_W'(1);
        end
      end
      always_ff @(posedge mclk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          acc_r             <= '0;
          scnt_r            <= '0;
          avg_r             <= '0;
          have_r            <= 1'b0;
          ncnt_r            <= '0;
          recal_req_o[gi]   <= 1'b0;
          base_update_o[gi] <= 1'b0;
          base_o[gi]        <= '0;
        end
        else
        begin
          acc_r             <= acc_nxt;
          scnt_r            <= scnt_nxt;
          avg_r             <= avg_nxt;
          have_r            <= have_nxt;
          ncnt_r            <= ncnt_nxt;
          recal_req_o[gi]   <= req_nxt;
          base_update_o[gi] <= upd_nxt;
          base_o[gi]        <= base_nxt;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: tpr_pkg.sv
// constants and types of the touch pattern and recalibration block
//
// Contract
// (R1) specific mode: event when set of hit inputs equals the mask set
// (R2) count mode: event when number of hit inputs reaches mask popcount
// (R3) one compare-mode bit in pattern config selects matching method
// (R4) six-bit read-write pattern mask, bit n-1 is input n, resets 3F
// (R5) read-only six-bit out-of-range status per input, resets to zero
// (R6) any out-of-range bit sets the summary fault bit
// (R7) broadcast bit set: input 1 threshold write updates all six thresholds
// (R8) keep-intermediate bit clear: noise clears intermediate accumulation
// (R9) keep-negative-count bit clear: noise clears negative delta counter
// (R10) host should program both keep bits to the same value
// (R11) negative run limit code gives 8, 16, 32 or disabled
// (R12) recal code sets averaged samples 16 to 256, codes above 4 give 256
// (R13) recal code sets update period 16 to 4096 sensing cycles, reset 010
// (R14) configured samples are averaged before update; period set separately
// (R15) recal settings common to all inputs; recal config resets to 8A
// (R16) compare-mode bit 0 selects count, 1 selects specific pattern
// (R17) pattern threshold fraction 12.5, 25, 37.5 or 100 percent of threshold
// (R18) pattern event blocks touches and raises alert when alert enabled
// (R19) bits 7 and 6 of mask and status read zero, ignore writes
package tpr_pkg;
  // ==========================================================
  // sizes
  localparam int NUM_IN    = 6;
  localparam int THR_W     = 7;
  localparam int DELTA_W   = 8;
  localparam int SAMPLE_W  = 16;
  localparam int ACC_W     = 24;
  localparam int SCNT_W    = 9;
  localparam int NCNT_W    = 6;
  localparam int PCNT_W    = 13;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_PCFG   = 8'h2B;
  localparam logic [7:0] ADDR_MASK   = 8'h2D;
  localparam logic [7:0] ADDR_OOR    = 8'h2E;
  localparam logic [7:0] ADDR_RECAL  = 8'h2F;
  localparam logic [7:0] ADDR_THR1   = 8'h30;
  localparam logic [7:0] ADDR_THR6   = 8'h35;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_PCFG    = 8'h00;
  localparam logic [5:0] RST_MASK    = 6'h3F;
  localparam logic [5:0] RST_OOR     = 6'h00;
  localparam logic [7:0] RST_RECAL   = 8'h8A;
  localparam logic [6:0] RST_THR     = 7'h40;
  // ==========================================================
  // field codes
  localparam logic [1:0] FRAC_12P5   = 2'h0;
  localparam logic [1:0] FRAC_25     = 2'h1;
  localparam logic [1:0] FRAC_37P5   = 2'h2;
  localparam logic [1:0] NEG_LIM_8   = 2'h0;
  localparam logic [1:0] NEG_LIM_16  = 2'h1;
  localparam logic [1:0] NEG_LIM_32  = 2'h2;
  localparam logic [5:0] NEG_CNT_8   = 6'h08;
  localparam logic [5:0] NEG_CNT_16  = 6'h10;
  localparam logic [5:0] NEG_CNT_32  = 6'h20;
  localparam logic [2:0] CAL_MAX_AVG = 3'h4;
  localparam logic [3:0] AVG_SH_BASE = 4'h4;
  localparam logic [3:0] AVG_SH_MAX  = 4'h8;
  localparam logic [3:0] PER_SH_5    = 4'hA;
  localparam logic [3:0] PER_SH_6    = 4'hB;
  localparam logic [3:0] PER_SH_7    = 4'hC;
  // ==========================================================
  // register layouts
  typedef struct packed {
    logic       detect_en;
    logic [2:0] rsv;
    logic [1:0] frac;
    logic       compare_mode_select;
    logic       alert_en;
  } tpr_pcfg_t;

  typedef struct packed {
    logic       threshold_broadcast;
    logic       keep_intermediate_on_noise;
    logic       keep_negative_count_on_noise;
    logic [1:0] negative_run_limit;
    logic [2:0] cal_cfg;
  } tpr_recal_t;

  // one register access from the serial bus engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tpr_reg_req_t;
endpackage

// file: tpr_pattern_match.sv
// multiple touch pattern matcher
`timescale 1ns/100ps
`default_nettype none
module tpr_pattern_match (
  // clock and reset
  input  wire logic                                     mclk_i,
  input  wire logic                                     reset_n_i,
  // sensing cycle data
  input  wire logic                                     cycle_done_i,
  input  wire logic [tpr_pkg::NUM_IN-1:0][tpr_pkg::DELTA_W-1:0] delta_i,
  input  wire logic [tpr_pkg::NUM_IN-1:0]               noise_i,
  // configuration
  input  wire logic [tpr_pkg::NUM_IN-1:0][tpr_pkg::THR_W-1:0]   thr_i,
  input  wire logic [tpr_pkg::NUM_IN-1:0]               mask_i,
  input  var  tpr_pkg::tpr_pcfg_t                       pcfg_i,
  // results
  output logic                                          event_o,
  output logic                                          block_o,
  output logic                                          alert_o
);
  // ==========================================================
  // per input hit
  logic [tpr_pkg::NUM_IN-1:0] hit;
  genvar gi;
  generate
    for (gi = 0; gi < tpr_pkg::NUM_IN; gi++)
    begin : g_hit
      logic [tpr_pkg::THR_W-1:0] pthr;
      always_comb
      begin
        case (pcfg_i.frac) // (R17)
          tpr_pkg::FRAC_12P5: pthr = thr_i[gi] >> 3;
          tpr_pkg::FRAC_25:   pthr = thr_i[gi] >> 2;
          tpr_pkg::FRAC_37P5: pthr = (thr_i[gi] >> 2) + (thr_i[gi] >> 3);
          default:            pthr = thr_i[gi];
        endcase
      end
      assign hit[gi] = (delta_i[gi] > {1'b0, pthr}) | noise_i[gi];
    end
  endgenerate

  // ==========================================================
  // compare
  logic [2:0] hit_cnt;
  logic [2:0] mask_cnt;
  logic       match;
  always_comb
  begin
    hit_cnt  = 3'h0;
    mask_cnt = 3'h0;
    for (int i = 0; i < tpr_pkg::NUM_IN; i++)
    begin
      hit_cnt  = hit_cnt + {2'h0, hit[i]};
      mask_cnt = mask_cnt + {2'h0, mask_i[i]};
    end
    if (pcfg_i.compare_mode_select) // (R3) (R16)
      match = (hit == mask_i); // (R1)
    else
      match = (hit_cnt >= mask_cnt); // (R2)
  end

  // ==========================================================
  // event, block and alert
  logic event_nxt;
  logic block_nxt;
  logic alert_nxt;
  always_comb
  begin
    event_nxt = cycle_done_i & pcfg_i.detect_en & match;
    alert_nxt = event_nxt & pcfg_i.alert_en; // (R18)
    block_nxt = block_o;
    if (cycle_done_i)
      block_nxt = pcfg_i.detect_en & match; // (R18)
    else if (!pcfg_i.detect_en)
      block_nxt = 1'b0;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      event_o <= 1'b0;
      block_o <= 1'b0;
      alert_o <= 1'b0;
    end
    else
    begin
      event_o <= event_nxt;
      block_o <= block_nxt;
      alert_o <= alert_nxt;
    end
  end
endmodule
`default_nettype wire

// file: tpr_top.sv
// touch pattern detection, baseline range status and recalibration control
`timescale 1ns/100ps
`default_nettype none
module tpr_top (
  // clock and reset
  input  wire logic                                       mclk_i,
  input  wire logic                                       reset_n_i,
  // register access from serial bus engine
  input  var  tpr_pkg::tpr_reg_req_t                      reg_req_i,
  output logic [7:0]                                      reg_rdata_o,
  // sensing front end
  input  wire logic                                       cycle_done_i,
  input  wire logic [tpr_pkg::NUM_IN-1:0][tpr_pkg::DELTA_W-1:0] delta_i,
  input  wire logic [tpr_pkg::NUM_IN-1:0]                 noise_i,
  input  wire logic [tpr_pkg::NUM_IN-1:0]                 sample_valid_i,
  input  wire logic [tpr_pkg::NUM_IN-1:0][tpr_pkg::SAMPLE_W-1:0] sample_i,
  input  wire logic [tpr_pkg::NUM_IN-1:0]                 neg_delta_i,
  input  wire logic [tpr_pkg::NUM_IN-1:0]                 range_fault_i,
  // pattern results
  output logic                                            pattern_match_event_o,
  output logic                                            touch_block_o,
  output logic                                            pattern_alert_o,
  // status and thresholds
  output logic                                            baseline_range_fault_summary_o,
  output logic [tpr_pkg::NUM_IN-1:0][tpr_pkg::THR_W-1:0]  thr_o,
  // recalibration
  output logic [tpr_pkg::NUM_IN-1:0]                      base_update_o,
  output logic [tpr_pkg::NUM_IN-1:0][tpr_pkg::SAMPLE_W-1:0] base_o,
  output logic [tpr_pkg::NUM_IN-1:0]                      recal_req_o
);
  // ==========================================================
  // registers
  tpr_pkg::tpr_pcfg_t          pcfg_r, pcfg_nxt;
  tpr_pkg::tpr_recal_t         recal_r, recal_nxt;
  logic [tpr_pkg::NUM_IN-1:0]  mask_r, mask_nxt;
  logic [tpr_pkg::NUM_IN-1:0]  oor_r, oor_nxt;
  logic [7:0]                  rdata_nxt;
  logic                        summary_nxt;
  logic [tpr_pkg::NUM_IN-1:0][tpr_pkg::THR_W-1:0] thr_nxt;

  // ==========================================================
  // write decode
  always_comb
  begin
    pcfg_nxt  = pcfg_r;
    recal_nxt = recal_r;
    mask_nxt  = mask_r;
    thr_nxt   = thr_o;
    if (reg_req_i.wr)
    begin
      case (reg_req_i.addr)
        tpr_pkg::ADDR_PCFG:
        begin
          pcfg_nxt     = tpr_pkg::tpr_pcfg_t'(reg_req_i.wdata);
          pcfg_nxt.rsv = 3'h0;
        end
        tpr_pkg::ADDR_MASK:  mask_nxt  = reg_req_i.wdata[tpr_pkg::NUM_IN-1:0]; // (R4) (R19)
        tpr_pkg::ADDR_RECAL: recal_nxt = tpr_pkg::tpr_recal_t'(reg_req_i.wdata); // (R15)
        default:
        begin
          for (int i = 0; i < tpr_pkg::NUM_IN; i++)
          begin
            if (reg_req_i.addr == tpr_pkg::ADDR_THR1 + 8'(i))
              thr_nxt[i] = reg_req_i.wdata[tpr_pkg::THR_W-1:0];
            else if (reg_req_i.addr == tpr_pkg::ADDR_THR1 && recal_r.threshold_broadcast)
              thr_nxt[i] = reg_req_i.wdata[tpr_pkg::THR_W-1:0]; // (R7)
          end
        end
      endcase
    end
  end

  // ==========================================================
  // status capture and read mux
  always_comb
  begin
    oor_nxt     = range_fault_i; // (R5)
    summary_nxt = |range_fault_i; // (R6)
    rdata_nxt   = reg_rdata_o;
    if (reg_req_i.rd)
    begin
      rdata_nxt = 8'h00;
      case (reg_req_i.addr)
        tpr_pkg::ADDR_PCFG:  rdata_nxt = pcfg_r;
        tpr_pkg::ADDR_MASK:  rdata_nxt = {2'h0, mask_r}; // (R19)
        tpr_pkg::ADDR_OOR:   rdata_nxt = {2'h0, oor_r}; // (R5) (R19)
        tpr_pkg::ADDR_RECAL: rdata_nxt = recal_r;
        default:
        begin
          for (int i = 0; i < tpr_pkg::NUM_IN; i++)
          begin
            if (reg_req_i.addr == tpr_pkg::ADDR_THR1 + 8'(i))
              rdata_nxt = {1'b0, thr_o[i]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pcfg_r                         <= tpr_pkg::tpr_pcfg_t'(tpr_pkg::RST_PCFG);
      recal_r                        <= tpr_pkg::tpr_recal_t'(tpr_pkg::RST_RECAL); // (R15)
      mask_r                         <= tpr_pkg::RST_MASK; // (R4)
      oor_r                          <= tpr_pkg::RST_OOR;
      thr_o                          <= {tpr_pkg::NUM_IN{tpr_pkg::RST_THR}};
      reg_rdata_o                    <= 8'h00;
      baseline_range_fault_summary_o <= 1'b0;
    end
    else
    begin
      pcfg_r                         <= pcfg_nxt;
      recal_r                        <= recal_nxt;
      mask_r                         <= mask_nxt;
      oor_r                          <= oor_nxt;
      thr_o                          <= thr_nxt;
      reg_rdata_o                    <= rdata_nxt;
      baseline_range_fault_summary_o <= summary_nxt;
    end
  end

  // ==========================================================
  // pattern matcher
  tpr_pattern_match u_match (
    .mclk_i       (mclk_i),
    .reset_n_i    (reset_n_i),
    .cycle_done_i (cycle_done_i),
    .delta_i      (delta_i),
    .noise_i      (noise_i),
    .thr_i        (thr_o),
    .mask_i       (mask_r),
    .pcfg_i       (pcfg_r),
    .event_o      (pattern_match_event_o),
    .block_o      (touch_block_o),
    .alert_o      (pattern_alert_o)
  );

  // ==========================================================
  // recalibration control, settings shared by all inputs
  tpr_recal_ctrl u_recal (
    .mclk_i         (mclk_i),
    .reset_n_i      (reset_n_i),
    .cycle_done_i   (cycle_done_i),
    .sample_valid_i (sample_valid_i),
    .sample_i       (sample_i),
    .neg_delta_i    (neg_delta_i),
    .noise_i        (noise_i),
    .cfg_i          (recal_r),
    .base_update_o  (base_update_o),
    .base_o         (base_o),
    .recal_req_o    (recal_req_o)
  );
endmodule
`default_nettype wire

// file: tpr_monitor.sv
// port checker of the touch pattern block
`timescale 1ns/100ps
`default_nettype none
module tpr_monitor (
  // clock and reset
  input wire logic            mclk_i,
  input wire logic            reset_n_i,
  // register access
  input var  tpr_pkg::tpr_reg_req_t reg_req_i,
  input wire logic [7:0]      reg_rdata_o,
  // sensing
  input wire logic            cycle_done_i,
  input wire logic [5:0]      sample_valid_i,
  input wire logic [5:0]      range_fault_i,
  // results
  input wire logic            pattern_match_event_o,
  input wire logic            touch_block_o,
  input wire logic            pattern_alert_o,
  input wire logic            baseline_range_fault_summary_o,
  input wire logic [5:0][6:0] thr_o,
  input wire logic [5:0]      base_update_o,
  input wire logic [5:0]      recal_req_o
);
  // ======================================
  // broadcast bit shadow
  logic bc_r;
  logic bc_nxt;
  always_comb
  begin
    bc_nxt = bc_r;
    if (reg_req_i.wr && reg_req_i.addr == 8'h2F) bc_nxt = reg_req_i.wdata[7];
  end
  always_ff @(posedge mclk_i or negedge reset_n_i)
    if (!reset_n_i) bc_r <= 1'b1;
    else bc_r <= bc_nxt;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // ======================================
  // checks
  a_summary_or: assert property (
    $past(reset_n_i) |-> baseline_range_fault_summary_o == |$past(range_fault_i))
    else $error("summary fault wrong");
  a_event_cause: assert property (
    pattern_match_event_o |-> $past(cycle_done_i)) else $error("event without cycle end");
  a_alert_gate: assert property (
    pattern_alert_o |-> pattern_match_event_o) else $error("alert without event");
  a_block_event: assert property (
    pattern_match_event_o |-> touch_block_o) else $error("event without block");
  a_block_rise: assert property (
    $rose(touch_block_o) |-> $past(cycle_done_i)) else $error("block rose early");
  a_thr_bcast: assert property (
    reg_req_i.wr && reg_req_i.addr == 8'h30 && bc_r
    |=> thr_o == {6{$past(reg_req_i.wdata[6:0])}}) else $error("broadcast missed");
  a_thr_single: assert property (
    reg_req_i.wr && (reg_req_i.addr inside {[8'h31:8'h35]} || reg_req_i.addr == 8'h30
    && !bc_r) |=> thr_o[$past(reg_req_i.addr[2:0])] == $past(reg_req_i.wdata[6:0]))
    else $error("threshold write lost");
  a_top_bits_zero: assert property (
    reg_req_i.rd && reg_req_i.addr inside {8'h2D, 8'h2E} |=> reg_rdata_o[7:6] == 2'b00)
    else $error("unused bits set");
  a_rdata_hold: assert property (
    !reg_req_i.rd |=> $stable(reg_rdata_o)) else $error("read data moved");
  a_recal_cause: assert property (
    recal_req_o != 6'h00 |-> (recal_req_o & ~$past(sample_valid_i)) == 6'h00)
    else $error("recal without sample");
  a_update_cause: assert property (
    base_update_o != 6'h00 |-> $past(cycle_done_i)) else $error("update off cycle");
endmodule
bind tpr_top tpr_monitor tpr_monitor_i (.mclk_i, .reset_n_i, .reg_req_i, .reg_rdata_o,
  .cycle_done_i, .sample_valid_i, .range_fault_i, .pattern_match_event_o, .touch_block_o,
  .pattern_alert_o, .baseline_range_fault_summary_o, .thr_o, .base_update_o, .recal_req_o);
`default_nettype wire

// file: tpr_host_model.sv
// host side register access model
`timescale 1ns/100ps
`default_nettype none
module tpr_host_model (
  // clock
  input  wire logic                  mclk_i,
  // register access
  output var tpr_pkg::tpr_reg_req_t  req_o,
  input  wire logic [7:0]            rdata_i
);
  // ======================================
  // access tasks
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] w;
    w = d;
    if (a == 8'h2F) w[5] = w[6];
    @(posedge mclk_i);
    req_o <= '{1'b1, 1'b0, a, w};
    @(posedge mclk_i);
    req_o <= '{1'b0, 1'b0, ~a, ~w};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    req_o <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_i);
    req_o <= '{1'b0, 1'b0, ~a, 8'hFF};
    #1;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// file: tpr_tb.sv
// self-checking testbench of the touch pattern block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ======================================
  // signals and model state
  logic clk = 0, rst_n = 0, cd = 0, ev, blk, al, sum, m;
  tpr_pkg::tpr_reg_req_t req;
  logic [7:0] rq, d;
  logic [5:0][7:0] dl = '0;
  logic [5:0] nz = '0, sv = '0, ng = '0, rf = '0, bu, rr, hit, z6;
  logic [5:0][15:0] sm = '0, bo;
  logic [5:0][6:0] th;
  logic [15:0] v;
  int fail_count = 0, checked = 0, tm[6], mk, pc, p, c, lim, n, k, last;
  always #12.5 clk = ~clk;
  tpr_host_model h (.mclk_i(clk), .req_o(req), .rdata_i(rq));
  tpr_top tpr_top_i (.mclk_i(clk), .reset_n_i(rst_n), .reg_req_i(req), .reg_rdata_o(rq),
    .cycle_done_i(cd), .delta_i(dl), .noise_i(nz), .sample_valid_i(sv), .sample_i(sm),
    .neg_delta_i(ng), .range_fault_i(rf), .pattern_match_event_o(ev), .touch_block_o(blk),
    .pattern_alert_o(al), .baseline_range_fault_summary_o(sum), .thr_o(th),
    .base_update_o(bu), .base_o(bo), .recal_req_o(rr));
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    h.rd(a, d);
    cmp(d, e);
  endtask
  task automatic samp(input logic g, input logic z);
    @(posedge clk);
    sv <= '1;
    ng <= {6{g}};
    nz <= {6{z}};
    sm <= {$urandom, $urandom, $urandom};
    @(posedge clk);
    sv <= '0;
    #1;
    if (z) c = 0;
    else if (g) c++;
    else c = 0;
    cmp(rr, {6{lim > 0 && c == lim}});
    if (c == lim) c = 0;
  endtask
  task automatic complete_run();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  initial
  begin
    void'($urandom(6552));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc(8'h2D, 8'h3F);
    rdc(8'h2E, 8'h00);
    rdc(8'h2F, 8'h8A);
    rdc(8'h2B, 8'h00);
    rdc(8'h10, 8'h00);
    @(posedge clk);
    rf <= $urandom;
    h.wr(8'h2E, 8'hFF);
    h.wr(8'h2D, 8'hFF);
    rdc(8'h2D, 8'h3F);
    rdc(8'h2E, {2'b00, rf});
    cmp(sum, |rf);
    h.wr(8'h30, 8'h55);
    for (int j = 0; j < 6; j++) rdc(8'(8'h30 + j), 8'h55);
    for (int j = 0; j < 6; j++) cmp(th[j], 7'h55);
    h.wr(8'h2F, 8'h0A);
    h.wr(8'h30, 8'h11);
    h.wr(8'h33, 8'h22);
    rdc(8'h30, 8'h11);
    rdc(8'h31, 8'h55);
    rdc(8'h33, 8'h22);
    h.wr(8'h2F, 8'h8A);
    // ======================================
    // pattern matching in both modes
    for (int i = 0; i < 60; i++)
    begin
      pc = $urandom;
      pc[7] = i % 8 != 7;
      h.wr(8'h2B, pc[7:0]);
      rdc(8'h2B, pc[7:0] & 8'h8F);
      d = $urandom;
      h.wr(8'h2D, d);
      mk = d[5:0];
      v = $urandom;
      k = 1 + $urandom % 5;
      h.wr(8'h30, {1'b0, v[6:0]});
      h.wr(8'(8'h30 + k), {1'b0, v[14:8]});
      for (int j = 0; j < 6; j++) tm[j] = j == k ? v[14:8] : v[6:0];
      n = i % 2 ? mk : $urandom;
      z6 = $urandom & $urandom & $urandom;
      @(posedge clk);
      for (int j = 0; j < 6; j++)
      begin
        p = pc[3:2] == 0 ? tm[j] >> 3 : pc[3:2] == 1 ? tm[j] >> 2 :
          pc[3:2] == 2 ? (tm[j] >> 2) + (tm[j] >> 3) : tm[j];
        dl[j] <= n[j] ? 8'(p + 1 + $urandom % 8) : 8'($urandom % (p + 1));
      end
      cd <= 1'b1;
      nz <= z6;
      @(posedge clk);
      cd <= 1'b0;
      nz <= '0;
      #1;
      hit = n[5:0] | z6;
      m = pc[7] && (pc[1] ? hit == mk[5:0] : $countones(hit) >= $countones(mk[5:0]));
      cmp(ev, m);
      cmp(al, m && pc[0]);
      cmp(blk, m);
      rdc(8'h2D, mk[7:0]);
    end
    // ======================================
    // recalibration periods and averages
    for (int cc = 0; cc < 8; cc++)
    begin
      h.wr(8'(8'h98 | cc), 8'h00);
      h.wr(8'h2F, 8'(8'h98 | cc));
      v = $urandom;
      n = 0;
      k = 0;
      last = 0;
      for (int t = 0; t < 40000 && n < 3; t++)
      begin
        @(posedge clk);
        k += cd;
        cd <= !cd;
        sv <= {6{!cd}};
        sm <= {6{v}};
        #1;
        if (|bu)
        begin
          n++;
          cmp(bu, 6'h3F);
          if (n == 3) cmp(k - last, cc < 5 ? 16 << cc : 1024 << (cc - 5));
          last = k;
        end
      end
      cmp(n, 3);
      for (int j = 0; j < 6; j++) cmp(bo[j], v);
    end
    @(posedge clk);
    cd <= 1'b0;
    sv <= '0;
    // ======================================
    // negative run limits and noise clearing
    for (int lc = 0; lc < 4; lc++)
    begin
      h.wr(8'h2F, 8'(8'h82 | (lc << 3)));
      lim = lc < 3 ? 8 << lc : 0;
      n = lc < 3 ? lim : 40;
      c = 0;
      for (int i = 1; i < n; i++) samp(1'b1, 1'b0);
      samp(1'b1, 1'b1);
      for (int i = 0; i < n; i++) samp(1'b1, 1'b0);
      samp(1'b0, 1'b0);
    end
    complete_run();
  end
endmodule
`default_nettype wire
